// *** hdl/azd_msg_decoder.sv ***
// decoder for the autozero and duty spi messages of an eight-channel current driver
// assumes frames arrive already deserialised, one per frame_valid pulse, on clk
`timescale 1ns/1ps
`include "azd_map.svh"

// What this block does
// - bit 31 read/write, selector 0111, channel field picks autozero of a channel
// - autozero write starts the channel's sequence and clears both done flags
// - both done flags set when the channel's autozero sequence finishes
// - autozero read starts nothing but clears both flags after reporting them
// - response bit 17 shows gate-high autozero happened since last autozero read or write
// - response bit 16 shows gate-low autozero happened since last autozero read or write
// - both done flags reset to zero
// - gate-high offset value returned in bits 15:8
// - gate-low offset value returned in bits 7:0
// - selector 1000 addresses duty; write carries bits 18:0, reset zero
// - written duty drives the output only in direct-pwm mode
// - duty written in current mode is kept and used once direct-pwm
// - duty read returns bits 20:0; current mode gives regulator duty
// - direct-pwm duty read returns written value with bits 11, 12 zero
// - direct-pwm on-fraction is duty over n times 32
// - current-mode on-fraction is duty over n times m
// - on-fraction saturates at full on above 100 percent
module azd_msg_decoder #(
	parameter int NCH = 8,
	parameter int PW = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire azd_pkg::azd_frame_t frame_in,
	input wire logic frame_valid,
	output azd_pkg::azd_frame_t frame_out,
	output logic frame_out_valid,
	input wire logic [NCH-1:0] direct_pwm_mode,
	input wire logic [PW-1:0] period_n,
	input wire logic [9:0] sample_m,
	input wire logic [NCH*21-1:0] regulator_duty,
	output logic [NCH-1:0] az_start,
	input wire logic [NCH-1:0] az_done,
	input wire logic [NCH*8-1:0] az_high_value,
	input wire logic [NCH*8-1:0] az_low_value,
	output logic [NCH-1:0] pwm_out
);
	import azd_pkg::*;

	// ----------------------------------------------------------------
	// frame decode
	// ----------------------------------------------------------------
	logic is_write, is_az, is_duty;
	logic [3:0] sel;
	azd_channel_select_t ch;

	// field split of the incoming frame
	always_comb begin
		is_write = frame_in[`AZD_RW_BIT];
		sel = frame_in[`AZD_SEL_HI:`AZD_SEL_LO];
		ch = frame_in[`AZD_CH_HI:`AZD_CH_LO];
		is_az = frame_valid && (sel == `AZD_SEL_AUTOZERO);
		is_duty = frame_valid && (sel == `AZD_SEL_DUTY);
	end

	// ----------------------------------------------------------------
	// per-channel state
	// ----------------------------------------------------------------
	logic [NCH-1:0] hi_flag_r, hi_flag_nxt;
	logic [NCH-1:0] lo_flag_r, lo_flag_nxt;
	logic [NCH-1:0] start_r, start_nxt;
	azd_duty_t duty_r [NCH];
	azd_duty_t duty_nxt [NCH];

	// done flags: completion wins over a clear in the same cycle so no event is lost
	always_comb begin
		hi_flag_nxt = hi_flag_r;
		lo_flag_nxt = lo_flag_r;
		start_nxt = '0;
		for (int i = 0; i < NCH; i++) begin
			duty_nxt[i] = duty_r[i];
		end
		if (is_az) begin
			// a read clears after reporting; the response is built from the old value
			hi_flag_nxt[ch] = 1'b0;
			lo_flag_nxt[ch] = 1'b0;
			if (is_write) begin
				start_nxt[ch] = 1'b1;
			end
		end
		hi_flag_nxt = hi_flag_nxt | az_done;
		lo_flag_nxt = lo_flag_nxt | az_done;
		// stored regardless of mode, so a later switch to direct-pwm picks it up
		if (is_duty && is_write) begin
			duty_nxt[ch] = frame_in[`AZD_DUTY_WR_HI:0];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hi_flag_r <= {NCH{`AZD_FLAG_RESET}};
			lo_flag_r <= {NCH{`AZD_FLAG_RESET}};
			start_r <= '0;
			for (int i = 0; i < NCH; i++) begin
				duty_r[i] <= `AZD_DUTY_RESET;
			end
		end else begin
			hi_flag_r <= hi_flag_nxt;
			lo_flag_r <= lo_flag_nxt;
			start_r <= start_nxt;
			for (int i = 0; i < NCH; i++) begin
				duty_r[i] <= duty_nxt[i];
			end
		end
	end
	// host is trusted to wait for current decay before a trigger; no check here
	assign az_start = start_r;

	// ----------------------------------------------------------------
	// response frame
	// ----------------------------------------------------------------
	azd_frame_t resp_r, resp_nxt;
	logic resp_v_r, resp_v_nxt;

	// duty readback per mode
	function automatic azd_rdduty_t rd_duty(input logic direct, input azd_duty_t wr, input azd_rdduty_t pi);
		azd_rdduty_t v;
		v = pi;
		if (direct) begin
			v = {2'b00, wr};
			v[`AZD_DUTY_MASK_HI:`AZD_DUTY_MASK_LO] = 2'b00;
		end
		return v;
	endfunction : rd_duty

	always_comb begin
		resp_nxt = resp_r;
		resp_v_nxt = 1'b0;
		if (is_az || is_duty) begin
			resp_v_nxt = 1'b1;
			resp_nxt = '0;
			resp_nxt[`AZD_SEL_HI:`AZD_SEL_LO] = sel;
			resp_nxt[`AZD_CH_HI:`AZD_CH_LO] = ch;
			if (is_az) begin
				resp_nxt[`AZD_HI_FLAG_BIT] = hi_flag_r[ch] | az_done[ch];
				resp_nxt[`AZD_LO_FLAG_BIT] = lo_flag_r[ch] | az_done[ch];
				resp_nxt[`AZD_HI_VAL_HI:`AZD_HI_VAL_LO] = az_high_value[ch*8 +: 8];
				resp_nxt[`AZD_LO_VAL_HI:`AZD_LO_VAL_LO] = az_low_value[ch*8 +: 8];
			end else begin
				resp_nxt[`AZD_DUTY_RD_HI:0] = rd_duty(direct_pwm_mode[ch], duty_r[ch],
					regulator_duty[ch*21 +: 21]);
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			resp_r <= '0;
			resp_v_r <= 1'b0;
		end else begin
			resp_r <= resp_nxt;
			resp_v_r <= resp_v_nxt;
		end
	end
	assign frame_out = resp_r;
	assign frame_out_valid = resp_v_r;

	// ----------------------------------------------------------------
	// output generation
	// ----------------------------------------------------------------
	// direct mode uses the stored spi duty over n*32, current mode the regulator over n*m
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		logic [20:0] eff_duty;
		logic [9:0] eff_scale;
		assign eff_duty = direct_pwm_mode[g] ? {2'b00, duty_r[g]} : regulator_duty[g*21 +: 21];
		assign eff_scale = direct_pwm_mode[g] ? 10'(`AZD_PWM_SCALE) : sample_m;
		azd_pwm_gen #(.DW(21), .PW(PW)) u_pwm (
			.clk(clk),
			.sys_rst(sys_rst),
			.duty(eff_duty),
			.period_n(period_n),
			.scale(eff_scale),
			.pwm_out(pwm_out[g])
		);

		// a duty only moves on a duty write to this very channel
		a_duty_write_only : assert property (@(posedge clk) disable iff (sys_rst)
			!(is_duty && is_write && ch == azd_channel_select_t'(g)) |=> $stable(duty_r[g]))
			else $error("stored duty changed without a write");

		// zero effective duty must keep the channel off
		a_pwm_zero_low : assert property (@(posedge clk) disable iff (sys_rst)
			(eff_duty == '0) [*2] |-> !pwm_out[g])
			else $error("channel on with zero duty");
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_az_write_start : assert property (@(posedge clk) disable iff (sys_rst)
		(is_az && is_write) |=> az_start[$past(ch)])
		else $error("autozero write did not start sequence");
	a_az_read_nostart : assert property (@(posedge clk) disable iff (sys_rst)
		(frame_valid && !(is_az && is_write)) |=> az_start == '0)
		else $error("autozero started without write");
	a_done_sets_flags : assert property (@(posedge clk) disable iff (sys_rst)
		(az_done != '0) |=> ((hi_flag_r & lo_flag_r & $past(az_done)) == $past(az_done)))
		else $error("done flags not set after completion");
	a_read_clears : assert property (@(posedge clk) disable iff (sys_rst)
		(is_az && !az_done[ch]) |=> !hi_flag_r[$past(ch)] && !lo_flag_r[$past(ch)])
		else $error("flags not cleared by access");
	a_resp_header : assert property (@(posedge clk) disable iff (sys_rst)
		frame_out_valid |-> !frame_out[`AZD_RW_BIT] && frame_out[30:27] == $past(sel))
		else $error("response header wrong");
	a_az_pad_zero : assert property (@(posedge clk) disable iff (sys_rst)
		(frame_out_valid && frame_out[30:27] == `AZD_SEL_AUTOZERO) |-> frame_out[23:18] == '0)
		else $error("autozero response pad not zero");
	a_duty_mask : assert property (@(posedge clk) disable iff (sys_rst)
		(is_duty && direct_pwm_mode[ch]) |=> frame_out[12:11] == 2'b00 && frame_out[23:21] == '0)
		else $error("direct duty readback bits 12:11 not zero");
	a_duty_stored : assert property (@(posedge clk) disable iff (sys_rst)
		(is_duty && is_write) |=> duty_r[$past(ch)] == $past(frame_in[18:0]))
		else $error("duty write not stored");
	a_az_value_echo : assert property (@(posedge clk) disable iff (sys_rst)
		is_az |=> frame_out[15:8] == $past(az_high_value[ch*8 +: 8]))
		else $error("gate-high offset value wrong");

	// ----------------------------------------------------------------
	// reset marker for the flag reset check
	// ----------------------------------------------------------------
	logic first_r, first_nxt;

	// high only in the first cycle after reset is let go
	always_comb begin
		first_nxt = 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			first_r <= 1'b1;
		end else begin
			first_r <= first_nxt;
		end
	end

	// ----------------------------------------------------------------
	// further checks on flags, starts, readback, response framing and outputs
	// ----------------------------------------------------------------
	// flags must leave reset cleared
	a_flags_from_reset : assert property (@(posedge clk) disable iff (sys_rst)
		first_r |-> hi_flag_r == '0 && lo_flag_r == '0)
		else $error("done flags not zero after reset");

	// gate-low offset byte follows the addressed channel
	a_lo_value_echo : assert property (@(posedge clk) disable iff (sys_rst)
		is_az |=> frame_out[`AZD_LO_VAL_HI:`AZD_LO_VAL_LO] == $past(az_low_value[ch*8 +: 8]))
		else $error("gate-low offset value wrong");

	// reported gate-high flag is the one held before the access, or-ed with a completion in the same cycle
	a_hi_flag_report : assert property (@(posedge clk) disable iff (sys_rst)
		is_az |=> frame_out[`AZD_HI_FLAG_BIT] == $past(hi_flag_r[ch] | az_done[ch]))
		else $error("gate-high flag report wrong");

	// reported gate-low flag is the one held before the access, or-ed with a completion in the same cycle
	a_lo_flag_report : assert property (@(posedge clk) disable iff (sys_rst)
		is_az |=> frame_out[`AZD_LO_FLAG_BIT] == $past(lo_flag_r[ch] | az_done[ch]))
		else $error("gate-low flag report wrong");

	// flags only move on an access or a completion
	a_flags_hold : assert property (@(posedge clk) disable iff (sys_rst)
		(!is_az && az_done == '0) |=> $stable(hi_flag_r) && $stable(lo_flag_r))
		else $error("done flags moved without cause");

	// completion in the same cycle as an access must not be lost
	a_done_wins : assert property (@(posedge clk) disable iff (sys_rst)
		(is_az && az_done[ch]) |=> hi_flag_r[$past(ch)] && lo_flag_r[$past(ch)])
		else $error("completion lost against a clear");

	// only one channel may be started at a time
	a_start_onehot : assert property (@(posedge clk) disable iff (sys_rst)
		(az_start != '0) |-> $onehot(az_start))
		else $error("more than one autozero start");

	// duty response pads above bit 20 are zero in both modes
	a_duty_pad_zero : assert property (@(posedge clk) disable iff (sys_rst)
		is_duty |=> frame_out[23:21] == '0)
		else $error("duty response pad not zero");

	// current mode reports the regulator duty unchanged
	a_current_readback : assert property (@(posedge clk) disable iff (sys_rst)
		(is_duty && !direct_pwm_mode[ch]) |=> frame_out[`AZD_DUTY_RD_HI:0] == $past(regulator_duty[ch*21 +: 21]))
		else $error("regulator duty readback wrong");

	// direct mode reports the stored duty outside the forced-zero bits
	a_direct_readback : assert property (@(posedge clk) disable iff (sys_rst)
		(is_duty && direct_pwm_mode[ch]) |=> frame_out[18:13] == $past(duty_r[ch][18:13])
		&& frame_out[10:0] == $past(duty_r[ch][10:0]))
		else $error("direct duty readback wrong");

	// the answer names the channel that was asked for
	a_resp_channel_select_echo : assert property (@(posedge clk) disable iff (sys_rst)
		frame_out_valid |-> frame_out[`AZD_CH_HI:`AZD_CH_LO] == $past(ch))
		else $error("response channel wrong");

	// an answer comes exactly for a decoded frame, never otherwise
	a_resp_only_decoded : assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |-> frame_out_valid == $past(is_az || is_duty))
		else $error("response pulse without decoded frame");

	// a zero period keeps every output low
	a_pwm_no_period : assert property (@(posedge clk) disable iff (sys_rst)
		(period_n == '0) [*2] |-> pwm_out == '0)
		else $error("output on with zero period");
endmodule : azd_msg_decoder

// *** hdl/azd_map.svh ***
// field positions, message codes and reset values of the autozero / duty message decoder
// assumes inclusion by the package and the design modules; definitions only
`ifndef AZD_MAP_SVH
`define AZD_MAP_SVH
`define AZD_RW_BIT 31
`define AZD_SEL_HI 30
`define AZD_SEL_LO 27
`define AZD_CH_HI 26
`define AZD_CH_LO 24
`define AZD_SEL_AUTOZERO 4'h7
`define AZD_SEL_DUTY 4'h8
`define AZD_HI_FLAG_BIT 17
`define AZD_LO_FLAG_BIT 16
`define AZD_HI_VAL_HI 15
`define AZD_HI_VAL_LO 8
`define AZD_LO_VAL_HI 7
`define AZD_LO_VAL_LO 0
`define AZD_DUTY_WR_HI 18
`define AZD_DUTY_RD_HI 20
`define AZD_DUTY_MASK_HI 12
`define AZD_DUTY_MASK_LO 11
`define AZD_DUTY_RESET 19'h00000
`define AZD_FLAG_RESET 1'h0
`define AZD_PWM_SCALE 32
`endif

// *** hdl/azd_pkg.sv ***
// types shared by the autozero / duty message decoder
// assumes azd_map.svh on the include path
`include "azd_map.svh"
package azd_pkg;
	typedef logic [31:0] azd_frame_t;
	typedef logic [2:0] azd_channel_select_t;
	typedef logic [18:0] azd_duty_t;
	typedef logic [20:0] azd_rdduty_t;
	typedef logic [7:0] azd_offs_t;
	typedef enum logic [1:0] {
		AZD_IDLE = 2'b00,
		AZD_RUN = 2'b01
	} azd_az_e;
endpackage : azd_pkg

// *** hdl/azd_pwm_gen.sv ***
// one channel pwm generator: on-fraction = duty / (n * scale), clipped at full on
// assumes n and scale come from the control configuration; same clock as the decoder
`timescale 1ns/1ps
`include "azd_map.svh"
module azd_pwm_gen #(
	parameter int DW = 21,
	parameter int PW = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [DW-1:0] duty,
	input wire logic [PW-1:0] period_n,
	input wire logic [9:0] scale,
	output logic pwm_out
);
	localparam int CW = PW + 10;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [CW-1:0] len;
	logic out_r, out_nxt;

	// period length in ticks; a zero length keeps the counter parked
	always_comb begin
		len = CW'(period_n) * CW'(scale);
		cnt_nxt = (cnt_r + CW'(1) >= len) ? '0 : cnt_r + CW'(1);
		// compare in the wide domain so a duty above the period saturates high
		out_nxt = (len != '0) && ((CW+DW)'(duty) > (CW+DW)'(cnt_r));
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= '0;
			out_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
		end
	end
	assign pwm_out = out_r;

	a_pwm_full_on : assert property (@(posedge clk) disable iff (sys_rst)
		(len != '0 && (CW+DW)'(duty) >= (CW+DW)'(len)) [*2] |-> out_r)
		else $error("pwm not saturated at full on");
endmodule : azd_pwm_gen

// *** bench/azd_host_model.sv ***
// host model: spi master side, one 32-bit frame per call, answer caught a cycle later
// assumes frames already deserialised; drives 1 ns after the rising edge of clk
`timescale 1ns/1ps
module azd_host_model (
	input wire logic clk,
	output azd_pkg::azd_frame_t frame_in,
	output logic frame_valid,
	input wire azd_pkg::azd_frame_t frame_out,
	input wire logic frame_out_valid
);
	import azd_pkg::*;
	initial begin
		frame_in = 32'h0000_0000;
		frame_valid = 1'b0;
	end
	// one transfer; idle line shows the inverse so a stale frame cannot pass as new
	task automatic xfer(input azd_frame_t f, output logic got, output azd_frame_t rsp);
		@(posedge clk);
		#1;
		frame_in = f;
		frame_valid = 1'b1;
		@(posedge clk);
		#1;
		frame_valid = 1'b0;
		frame_in = ~f;
		got = frame_out_valid;
		rsp = frame_out;
	endtask : xfer
	// wait for recirculation decay before an autozero start
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask : settle
endmodule : azd_host_model

// *** bench/azd_msg_decoder_tb.sv ***
// self-checking bench of the autozero / duty message decoder
// assumes azd_pkg compiled first and the host model beside it
`timescale 1ns/1ps
module azd_msg_decoder_tb;
	import azd_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	azd_frame_t frame_in, frame_out, rsp;
	logic frame_valid, frame_out_valid, got;
	logic [7:0] direct_pwm_mode = 8'hFF;
	logic [15:0] period_n = 16'h0002;
	logic [9:0] sample_m = 10'h004;
	logic [167:0] regulator_duty;
	logic [7:0] az_start, pwm_out;
	logic [7:0] az_done = 8'h00;
	logic [63:0] az_high_value = 64'hF1E2_D3C4_B5A6_9788;
	logic [63:0] az_low_value = 64'h0F1E_2D3C_4B5A_6978;
	int miscompares = 0;
	int compares = 0;
	// regulator duty of channel i is i, so channel 2 gives 2 / (n*m) = 1/4
	initial begin
		for (int i = 0; i < 8; i++) begin
			regulator_duty[i*21 +: 21] = 21'(i);
		end
	end
	always #2 clk = ~clk;
	azd_msg_decoder dut (.clk(clk), .sys_rst(sys_rst), .frame_in(frame_in), .frame_valid(frame_valid),
		.frame_out(frame_out), .frame_out_valid(frame_out_valid), .direct_pwm_mode(direct_pwm_mode),
		.period_n(period_n), .sample_m(sample_m), .regulator_duty(regulator_duty), .az_start(az_start),
		.az_done(az_done), .az_high_value(az_high_value), .az_low_value(az_low_value), .pwm_out(pwm_out));
	azd_host_model host (.clk(clk), .frame_in(frame_in), .frame_valid(frame_valid), .frame_out(frame_out),
		.frame_out_valid(frame_out_valid));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	function automatic azd_frame_t fr(input logic rw, input logic [3:0] sel, input logic [2:0] ch,
		input logic [23:0] d);
		return {rw, sel, ch, d};
	endfunction : fr
	task automatic done_pulse(input logic [7:0] m);
		@(posedge clk);
		#1;
		az_done = m;
		@(posedge clk);
		#1;
		az_done = 8'h00;
	endtask : done_pulse
	// count high cycles over a whole number of periods so phase does not matter
	task automatic count_hi(input int ch, input logic [31:0] exp);
		int n;
		n = 0;
		repeat (128) @(posedge clk);
		repeat (256) begin
			@(posedge clk);
			#1;
			n += int'(pwm_out[ch]);
		end
		chk(32'(n), exp);
	endtask : count_hi
	task automatic results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_read;
		host.xfer(fr(1'b0, 4'h7, 3'h1, 24'h0), got, rsp);
		chk({23'h0, got, az_start}, {23'h0, 1'b1, 8'h00});
		chk(rsp, 32'h3900_9769);
		host.xfer(fr(1'b0, 4'h8, 3'h0, 24'h0), got, rsp);
		chk(rsp, 32'h4000_0000);
	endtask : t_reset_read
	task automatic t_autozero;
		host.settle(4);
		host.xfer(fr(1'b1, 4'h7, 3'h3, 24'h0), got, rsp);
		chk({23'h0, got, az_start}, {23'h0, 1'b1, 8'h08});
		done_pulse(8'h08);
		host.xfer(fr(1'b1, 4'h7, 3'h3, 24'h0), got, rsp);
		host.xfer(fr(1'b0, 4'h7, 3'h3, 24'h0), got, rsp);
		chk(rsp, 32'h3B00_B54B);
		done_pulse(8'h08);
		host.xfer(fr(1'b0, 4'h7, 3'h3, 24'h0), got, rsp);
		chk(rsp, 32'h3B03_B54B);
		host.xfer(fr(1'b0, 4'h7, 3'h3, 24'h0), got, rsp);
		chk(rsp, 32'h3B00_B54B);
	endtask : t_autozero
	task automatic t_duty;
		host.xfer(fr(1'b1, 4'h8, 3'h5, 24'h07_FFFF), got, rsp);
		host.xfer(fr(1'b0, 4'h8, 3'h5, 24'h0), got, rsp);
		chk(rsp, 32'h4507_E7FF);
		direct_pwm_mode[2] = 1'b0;
		host.xfer(fr(1'b1, 4'h8, 3'h2, 24'h00_00A0), got, rsp);
		host.xfer(fr(1'b0, 4'h8, 3'h2, 24'h0), got, rsp);
		chk(rsp, 32'h4200_0002);
		direct_pwm_mode[2] = 1'b1;
		host.xfer(fr(1'b0, 4'h8, 3'h2, 24'h0), got, rsp);
		chk(rsp, 32'h4200_00A0);
	endtask : t_duty
	// a foreign selector must leave no answer and no start pulse
	task automatic t_refuse;
		host.xfer(fr(1'b1, 4'h9, 3'h0, 24'h0), got, rsp);
		chk({23'h0, got, az_start}, 32'h0000_0000);
	endtask : t_refuse
	task automatic t_pwm;
		host.xfer(fr(1'b1, 4'h8, 3'h0, 24'h00_0020), got, rsp);
		count_hi(0, 32'h0000_0080);
		host.xfer(fr(1'b1, 4'h8, 3'h0, 24'h00_0100), got, rsp);
		count_hi(0, 32'h0000_0100);
		direct_pwm_mode[2] = 1'b0;
		count_hi(2, 32'h0000_0040);
	endtask : t_pwm
	// main sequence after a three-cycle reset
	initial begin
		repeat (3) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_reset_read();
		t_autozero();
		t_duty();
		t_refuse();
		t_pwm();
		results();
	end
	// watchdog sized well above the roughly 1200 cycles the tests need
	initial begin
		#40000;
		miscompares++;
		results();
	end
endmodule : azd_msg_decoder_tb
